// ---- src/cam_pkg.sv ----
// =============================================================
// Shared constants of the cooler alarm monitor
// =============================================================
package cam_pkg;
   // Bus widths
   localparam int unsigned DATA_W = 32; // Register data width
   localparam int unsigned ADDR_W = 8; // Register byte address width
   localparam int unsigned TEMP_W = 16; // Signed tenths of a degree C

   // =============================================================
   // Clock and time base
   // =============================================================
   localparam longint unsigned CLK_HZ = 64'd250_000_000; // 4 ns period
   localparam longint unsigned SEC_S = 64'd1; // One second
   localparam int unsigned SEC_CYCLES_DEF = int'(CLK_HZ * SEC_S);
   localparam int unsigned SEC_PER_MIN = 60; // Minute in seconds

   // Qualification times, in their own units
   localparam int unsigned T_PUMP_ON_S = 10; // Run contact held on
   localparam int unsigned T_NOCUR_S = 3; // Current switch held false
   localparam int unsigned T_QUAL_S = 3; // Generic 3 s qualification
   localparam int unsigned T_BASIN_MIN = 5; // Basin level trigger
   localparam int unsigned T_DRAIN_MIN = 45; // Drain fault trigger

   // Temperature thresholds in tenths of a degree C
   localparam logic signed [TEMP_W-1:0] WATER_LO_DC = 16'sh0064; // 10.0
   localparam logic signed [TEMP_W-1:0] GLYCOL_LO_DC = 16'sh0048; // 7.2
   localparam logic signed [TEMP_W-1:0] WATER_HI_DC = 16'sh0082; // 13.0
   localparam logic signed [TEMP_W-1:0] GLYCOL_HI_DC = 16'sh0066; // 10.2

   // Occurrences that lock a pump out
   localparam int unsigned OCC_W = 2;
   localparam logic [OCC_W-1:0] LOCK_COUNT = 2'h3;

   // =============================================================
   // Register map
   // =============================================================
   localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00; // Control type
   localparam logic [ADDR_W-1:0] REG_LOCK_CLR = 8'h04; // Lockout clear
   localparam logic [ADDR_W-1:0] REG_ALARM = 8'h08; // Live alarms
   localparam logic [ADDR_W-1:0] REG_INT_STAT = 8'h0c; // Sticky, W1C
   localparam logic [ADDR_W-1:0] REG_INT_MASK = 8'h10; // Interrupt mask
   localparam logic [ADDR_W-1:0] REG_LOCK_STAT = 8'h14; // Locked pumps
   localparam int unsigned CTRL_LFT_BIT = 0; // Leaving temp control
   localparam int unsigned CTRL_GLY_BIT = 1; // Fluid is glycol
   localparam logic CTRL_LFT_RST = 1'h1;
   localparam logic CTRL_GLY_RST = 1'h0;
   localparam int unsigned LOCK_OCC_BASE = 16; // Counts, 2 bits each

   // Alarm vector layout
   localparam int unsigned ALM_LFT = 0; // Low leaving fluid temp
   localparam int unsigned ALM_LOWB = 1; // Low basin water
   localparam int unsigned ALM_HIB = 2; // High basin water
   localparam int unsigned ALM_DRN = 3; // Drain fault
   localparam int unsigned ALM_PUMP_BASE = 4; // No-current, then lockout

   // Field input layout
   localparam int unsigned IN_LOWF = 0; // Low float
   localparam int unsigned IN_HIGHF = 1; // High float
   localparam int unsigned IN_DRAIN = 2; // Drain valve open
   localparam int unsigned IN_PUMP_BASE = 3; // Contacts, then currents

   // Timer index layout
   localparam int unsigned TI_LFT_LO = 0;
   localparam int unsigned TI_LFT_HI = 1;
   localparam int unsigned TI_LOWB_SET = 2;
   localparam int unsigned TI_LOWB_CLR = 3;
   localparam int unsigned TI_HIB_SET = 4;
   localparam int unsigned TI_HIB_CLR = 5;
   localparam int unsigned TI_DRN_SET = 6;
   localparam int unsigned TI_DRN_CLR = 7;
   localparam int unsigned TI_PUMP_BASE = 8; // On, then no-current
endpackage : cam_pkg

// ---- src/cam_qual_if.sv ----
`timescale 1ns/100ps
// =============================================================
// Condition and result of one qualification timer
// =============================================================
interface cam_qual_if;
   logic cond; // Condition being qualified
   logic done; // Condition held long enough
   modport ctl (output cond, input done);
   modport tmr (input cond, output done);
endinterface : cam_qual_if

// ---- src/cam_qual_timer.sv ----
`timescale 1ns/100ps
// =============================================================
// Uninterrupted-duration timer
// =============================================================
module cam_qual_timer #(
   parameter int unsigned SEC_CYCLES = cam_pkg::SEC_CYCLES_DEF,
   parameter int unsigned LIMIT_S = 1
) (
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   cam_qual_if.tmr qt
);
   import cam_pkg::*;

   localparam int unsigned CW = (SEC_CYCLES > 2) ? $clog2(SEC_CYCLES) : 1;
   localparam int unsigned SW = $clog2(LIMIT_S + 1);

   // Refuse sizes the counters cannot serve
   if (SEC_CYCLES < 2 || LIMIT_S < 1) begin : g_chk
      $error("cam_qual_timer: SEC_CYCLES >= 2 and LIMIT_S >= 1");
   end

   typedef struct packed {
      logic [CW-1:0] cyc; // Cycles into current second
      logic [SW-1:0] sec; // Whole seconds held
      logic done; // Saturated result
   } cam_tmr_s;

   cam_tmr_s s_q;
   cam_tmr_s s_d;

   // =============================================================
   // Next state
   // =============================================================
   // Own prescaler restarts with the condition, so the wait is exact
   always_comb begin
      s_d = s_q;
      if (!qt.cond) begin
         s_d = '0;
      end else if (!s_q.done) begin
         if (s_q.cyc == CW'(SEC_CYCLES - 1)) begin
            s_d.cyc = '0;
            s_d.sec = s_q.sec + SW'(1);
            if (s_q.sec == SW'(LIMIT_S - 1)) begin
               s_d.done = 1'b1;
            end
         end else begin
            s_d.cyc = s_q.cyc + CW'(1);
         end
      end
   end

   // State register, frozen while the enable is low
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s_q <= '0;
      end else if (ce_in) begin
         s_q <= s_d;
      end
   end

   assign qt.done = s_q.done;

   // =============================================================
   // Checks
   // =============================================================
   tmr_restart_a: assert property (@(posedge ref_clk_in)
      disable iff (!rst_b_in || !ce_in)
      !qt.cond |=> !qt.done && s_q.sec == '0)
      else $error("timer did not restart when condition broke");

   tmr_done_a: assert property (@(posedge ref_clk_in)
      disable iff (!rst_b_in || !ce_in)
      $rose(qt.done) |-> $past(qt.cond) && $past(s_q.sec) == SW'(LIMIT_S - 1))
      else $error("timer finished without full duration");
endmodule : cam_qual_timer

// ---- src/cam_alarm_mon.sv ----
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/100ps
// =============================================================
// Cooler alarm monitor
// =============================================================
// Overview of operation
// - No-current alarm: contact 10 s, no current 3 s
// - Release on contact off or current present
// - Third no-current alarm locks pump until panel clear
// - Lockout alarm follows lockout until cleared
// - Locked pump gets no start command
// - Water: low temp alarm at or below 10.0
// - Glycol: low temp alarm at or below 7.2
// - Release above 13.0 or 10.2 for 3 s
// - Release whenever not leaving-temperature control
// - Low temp alarm raises emergency flag
// - Low basin: drain closed, float false 5 min
// - Low basin releases: low float true 3 s
// - High basin: high float true 5 min
// - High basin releases: high float false 3 s
// - Drain fault: drain open, float true 45 min
// - Drain fault releases: low float false 3 s
module cam_alarm_mon #(
   parameter int unsigned NUM_PUMPS = 2,
   parameter int unsigned SEC_CYCLES = cam_pkg::SEC_CYCLES_DEF
) (
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   input wire logic [NUM_PUMPS-1:0] pump_contact_in,
   input wire logic [NUM_PUMPS-1:0] pump_current_in,
   input wire logic low_float_in,
   input wire logic high_float_in,
   input wire logic drain_open_in,
   input wire logic signed [cam_pkg::TEMP_W-1:0] temp_in,
   input wire logic [NUM_PUMPS-1:0] pump_start_cmd_in,
   input wire logic [cam_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic [cam_pkg::DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [cam_pkg::DATA_W-1:0] reg_rdata_out,
   output logic [NUM_PUMPS-1:0] pump_start_out,
   output logic [cam_pkg::ALM_PUMP_BASE+2*NUM_PUMPS-1:0] alarm_out,
   output logic summary_alarm_out,
   output logic emergency_out,
   output logic irq_out
);
   import cam_pkg::*;

   localparam int unsigned NP = NUM_PUMPS;
   localparam int unsigned NIN = IN_PUMP_BASE + 2 * NP; // Field inputs
   localparam int unsigned AW = ALM_PUMP_BASE + 2 * NP; // Alarm bits
   localparam int unsigned NT = TI_PUMP_BASE + 2 * NP; // Timers

   // Pump count must fit the 32-bit status words and count fields
   if (NP < 1 || NP > 8) begin : g_chk
      $error("cam_alarm_mon: NUM_PUMPS must be 1 to 8");
   end

   typedef struct packed {
      logic [NIN-1:0] s1; // Synchroniser stage 1
      logic [NIN-1:0] s2; // Synchroniser stage 2
      logic [NIN-1:0] s3; // Synchroniser stage 3
      logic [NIN-1:0] filt; // Accepted field level
      logic leaving_temp_control_type; // Leaving-temperature control selected
      logic glycol; // Fluid is glycol
      logic [AW-1:0] alm; // Active alarms
      logic [AW-1:0] istat; // Sticky alarm events
      logic [AW-1:0] imask; // Interrupt enables
      logic [NP-1:0][OCC_W-1:0] occ; // No-current occurrences
      logic [NP-1:0] lock; // Pump locked out
      logic [NP-1:0] start; // Gated start commands
      logic summary; // Any alarm
      logic emerg; // Emergency flag
      logic irq; // Interrupt request
      logic [DATA_W-1:0] rdata; // Read answer
   } cam_st_s;

   cam_st_s s_q;
   cam_st_s s_d;
   logic [NT-1:0] tmr_cond; // Conditions into the timers
   logic [NT-1:0] tmr_done; // Qualified conditions

   // =============================================================
   // Helper functions
   // =============================================================
   // Write strobe aimed at one register
   function automatic logic wr_hit(input logic wr,
                                   input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] ofs);
      wr_hit = wr && (addr == ofs);
   endfunction : wr_hit

   // Seconds each timer must see its condition unbroken
   function automatic int unsigned tmr_limit(input int unsigned idx);
      if (idx >= TI_PUMP_BASE) begin
         tmr_limit = ((idx - TI_PUMP_BASE) % 2 == 0) ? T_PUMP_ON_S
                                                     : T_NOCUR_S;
      end else if (idx == TI_LOWB_SET || idx == TI_HIB_SET) begin
         tmr_limit = T_BASIN_MIN * SEC_PER_MIN;
      end else if (idx == TI_DRN_SET) begin
         tmr_limit = T_DRAIN_MIN * SEC_PER_MIN;
      end else begin
         tmr_limit = T_QUAL_S;
      end
   endfunction : tmr_limit

   // =============================================================
   // Qualification timers
   // =============================================================
   for (genvar i = 0; i < NT; i++) begin : g_tmr
      cam_qual_if u_q ();
      assign u_q.cond = tmr_cond[i];
      assign tmr_done[i] = u_q.done;
      cam_qual_timer #(
         .SEC_CYCLES(SEC_CYCLES),
         .LIMIT_S(tmr_limit(i))
      ) u_tmr (
         .ref_clk_in(ref_clk_in),
         .rst_b_in(rst_b_in),
         .ce_in(ce_in),
         .qt(u_q)
      );
   end

   // Decoded bus events; the lockout clear is shared with the checks
   logic [NP-1:0] lock_clr; // Panel clears lockout
   logic [AW-1:0] ist_w1c; // Sticky bits written with one
   assign lock_clr = wr_hit(reg_wr_in, reg_addr_in, REG_LOCK_CLR)
                     ? reg_wdata_in[NP-1:0] : '0;
   assign ist_w1c = wr_hit(reg_wr_in, reg_addr_in, REG_INT_STAT)
                    ? reg_wdata_in[AW-1:0] : '0;

   // =============================================================
   // Next state
   // =============================================================
   always_comb begin
      logic lowf;
      logic highf;
      logic drain;
      logic lo_hit;
      logic hi_hit;
      logic [NP-1:0] nc_set;
      logic [OCC_W-1:0] occ_n;
      lowf = s_q.filt[IN_LOWF];
      highf = s_q.filt[IN_HIGHF];
      drain = s_q.filt[IN_DRAIN];
      lo_hit = 1'b0;
      hi_hit = 1'b0;
      nc_set = '0;
      occ_n = '0;
      s_d = s_q;

      // Three-stage synchroniser; a level counts once 2 and 3 agree
      s_d.s1 = {pump_current_in, pump_contact_in,
                drain_open_in, high_float_in, low_float_in};
      s_d.s2 = s_q.s1;
      s_d.s3 = s_q.s2;
      for (int b = 0; b < NIN; b++) begin
         if (s_q.s2[b] == s_q.s3[b]) begin
            s_d.filt[b] = s_q.s3[b];
         end
      end

      // Temperature thresholds for the chosen fluid
      if (s_q.glycol) begin
         lo_hit = temp_in <= GLYCOL_LO_DC;
         hi_hit = temp_in > GLYCOL_HI_DC;
      end else begin
         lo_hit = temp_in <= WATER_LO_DC;
         hi_hit = temp_in > WATER_HI_DC;
      end

      // Conditions under qualification
      tmr_cond = '0;
      tmr_cond[TI_LFT_LO] = s_q.leaving_temp_control_type && lo_hit;
      tmr_cond[TI_LFT_HI] = s_q.leaving_temp_control_type && hi_hit;
      tmr_cond[TI_LOWB_SET] = !drain && !lowf;
      tmr_cond[TI_LOWB_CLR] = lowf;
      tmr_cond[TI_HIB_SET] = highf;
      tmr_cond[TI_HIB_CLR] = !highf;
      tmr_cond[TI_DRN_SET] = drain && lowf;
      tmr_cond[TI_DRN_CLR] = !lowf;
      for (int p = 0; p < NP; p++) begin
         tmr_cond[TI_PUMP_BASE + 2 * p] =
            s_q.filt[IN_PUMP_BASE + p];
         tmr_cond[TI_PUMP_BASE + 2 * p + 1] =
            !s_q.filt[IN_PUMP_BASE + NP + p];
      end

      // Low leaving temperature; leaving other control releases
      if (!s_q.leaving_temp_control_type || tmr_done[TI_LFT_HI]) begin
         s_d.alm[ALM_LFT] = 1'b0;
      end
      // Timer result lags a cycle; it must not outlast a control change
      if (s_q.leaving_temp_control_type && tmr_done[TI_LFT_LO]) begin
         s_d.alm[ALM_LFT] = 1'b1;
      end

      // Basin level and drain alarms; set beats release
      s_d.alm[ALM_LOWB] = tmr_done[TI_LOWB_SET] ||
         (s_q.alm[ALM_LOWB] && !tmr_done[TI_LOWB_CLR]);
      s_d.alm[ALM_HIB] = tmr_done[TI_HIB_SET] ||
         (s_q.alm[ALM_HIB] && !tmr_done[TI_HIB_CLR]);
      s_d.alm[ALM_DRN] = tmr_done[TI_DRN_SET] ||
         (s_q.alm[ALM_DRN] && !tmr_done[TI_DRN_CLR]);

      // Pump supervision
      for (int p = 0; p < NP; p++) begin
         // Set needs both timers; release is immediate
         // Timer results lag a cycle; live levels keep release first
         nc_set[p] = tmr_done[TI_PUMP_BASE + 2 * p] &&
                     tmr_done[TI_PUMP_BASE + 2 * p + 1] &&
                     s_q.filt[IN_PUMP_BASE + p] &&
                     !s_q.filt[IN_PUMP_BASE + NP + p];
         if (!s_q.filt[IN_PUMP_BASE + p] ||
             s_q.filt[IN_PUMP_BASE + NP + p]) begin
            s_d.alm[ALM_PUMP_BASE + p] = 1'b0;
         end
         if (nc_set[p]) begin
            s_d.alm[ALM_PUMP_BASE + p] = 1'b1;
         end
         // Panel clear first, so a same-cycle occurrence still counts
         occ_n = s_q.occ[p];
         if (lock_clr[p]) begin
            s_d.lock[p] = 1'b0;
            occ_n = '0;
         end
         if (nc_set[p] && !s_q.alm[ALM_PUMP_BASE + p] &&
             occ_n != LOCK_COUNT) begin
            occ_n = occ_n + OCC_W'(1);
            if (occ_n == LOCK_COUNT) begin
               s_d.lock[p] = 1'b1;
            end
         end
         s_d.occ[p] = occ_n;
         s_d.alm[ALM_PUMP_BASE + NP + p] = s_d.lock[p];
         s_d.start[p] = pump_start_cmd_in[p] && !s_d.lock[p];
      end

      // Summary and emergency follow the new alarm set
      s_d.summary = |s_d.alm;
      s_d.emerg = s_d.alm[ALM_LFT];

      // Control and interrupt mask registers
      if (wr_hit(reg_wr_in, reg_addr_in, REG_CTRL)) begin
         s_d.leaving_temp_control_type = reg_wdata_in[CTRL_LFT_BIT];
         s_d.glycol = reg_wdata_in[CTRL_GLY_BIT];
      end
      if (wr_hit(reg_wr_in, reg_addr_in, REG_INT_MASK)) begin
         s_d.imask = reg_wdata_in[AW-1:0];
      end

      // Sticky events: a new alarm beats a write-one clear
      s_d.istat = (s_q.istat & ~ist_w1c) | (s_d.alm & ~s_q.alm);
      s_d.irq = |(s_d.istat & s_d.imask);

      // Read data stand for one cycle only; unmapped reads zero
      s_d.rdata = '0;
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            REG_CTRL: begin
               s_d.rdata[CTRL_LFT_BIT] = s_q.leaving_temp_control_type;
               s_d.rdata[CTRL_GLY_BIT] = s_q.glycol;
            end
            REG_ALARM: s_d.rdata = DATA_W'(s_q.alm);
            REG_INT_STAT: s_d.rdata = DATA_W'(s_q.istat);
            REG_INT_MASK: s_d.rdata = DATA_W'(s_q.imask);
            REG_LOCK_STAT: begin
               s_d.rdata[NP-1:0] = s_q.lock;
               s_d.rdata[LOCK_OCC_BASE +: NP * OCC_W] = s_q.occ;
            end
            default: s_d.rdata = '0;
         endcase
      end
   end

   // =============================================================
   // State register
   // =============================================================
   // Clock enable freezes everything, bus answers included
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s_q <= '0;
         s_q.leaving_temp_control_type <= CTRL_LFT_RST;
         s_q.glycol <= CTRL_GLY_RST;
      end else if (ce_in) begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state flops
   assign reg_rdata_out = s_q.rdata;
   assign pump_start_out = s_q.start;
   assign alarm_out = s_q.alm;
   assign summary_alarm_out = s_q.summary;
   assign emergency_out = s_q.emerg;
   assign irq_out = s_q.irq;

   // =============================================================
   // Checks
   // =============================================================
   sequence pump_qual_s;
      tmr_done[TI_PUMP_BASE] && tmr_done[TI_PUMP_BASE + 1] &&
      s_q.filt[IN_PUMP_BASE] && !s_q.filt[IN_PUMP_BASE + NP];
   endsequence

   sequence lock_held_s;
      alarm_out[ALM_PUMP_BASE + NP] && !lock_clr[0];
   endsequence

   nocur_set_a: assert property (@(posedge ref_clk_in)
      disable iff (!rst_b_in || !ce_in)
      pump_qual_s |=> alarm_out[ALM_PUMP_BASE])
      else $error("no-current alarm missed after qualification");

   nocur_rel_a: assert property (@(posedge ref_clk_in)
      disable iff (!rst_b_in || !ce_in)
      !s_q.filt[IN_PUMP_BASE] ##1 !s_q.filt[IN_PUMP_BASE]
      |-> !alarm_out[ALM_PUMP_BASE])
      else $error("no-current alarm held with contact off");

   lock_count_a: assert property (@(posedge ref_clk_in)
      disable iff (!rst_b_in || !ce_in)
      $rose(s_q.lock[0]) |-> $past(tmr_done[TI_PUMP_BASE + 1]) &&
      $past(s_q.occ[0]) == LOCK_COUNT - OCC_W'(1))
      else $error("lockout set without third occurrence");

   lock_alarm_a: assert property (@(posedge ref_clk_in)
      disable iff (!rst_b_in || !ce_in)
      lock_held_s |=> alarm_out[ALM_PUMP_BASE + NP])
      else $error("lockout alarm dropped without panel clear");

   start_inh_a: assert property (@(posedge ref_clk_in)
      disable iff (!rst_b_in || !ce_in)
      s_q.lock[0] && !lock_clr[0] |=> !pump_start_out[0])
      else $error("locked pump was started");

   lft_set_a: assert property (@(posedge ref_clk_in)
      disable iff (!rst_b_in || !ce_in)
      $rose(alarm_out[ALM_LFT]) |-> $past(tmr_done[TI_LFT_LO]) &&
      $past(s_q.leaving_temp_control_type))
      else $error("low temperature alarm without qualification");

   lft_rel_a: assert property (@(posedge ref_clk_in)
      disable iff (!rst_b_in || !ce_in)
      !s_q.leaving_temp_control_type ##1 !s_q.leaving_temp_control_type |-> !alarm_out[ALM_LFT])
      else $error("low temperature alarm outside its control type");

   emerg_flag_a: assert property (@(posedge ref_clk_in)
      disable iff (!rst_b_in || !ce_in)
      $rose(alarm_out[ALM_LFT]) |-> emergency_out ##1
      (emergency_out == alarm_out[ALM_LFT]))
      else $error("emergency flag not tracking low temperature");

   basin_set_a: assert property (@(posedge ref_clk_in)
      disable iff (!rst_b_in || !ce_in)
      $rose(alarm_out[ALM_LOWB]) |-> $past(tmr_done[TI_LOWB_SET]))
      else $error("low basin alarm without 5 minutes");

   drain_flt_a: assert property (@(posedge ref_clk_in)
      disable iff (!rst_b_in || !ce_in)
      tmr_done[TI_DRN_SET] |=> alarm_out[ALM_DRN] && summary_alarm_out)
      else $error("drain fault not raised");

   summary_out_a: assert property (@(posedge ref_clk_in)
      disable iff (!rst_b_in || !ce_in)
      summary_alarm_out == (|alarm_out))
      else $error("summary alarm disagrees with alarms");
endmodule : cam_alarm_mon

// ---- dv/cam_field_model.sv ----
`timescale 1ns/100ps
// =========================================
// Field side: pump contactors, current switches
// =========================================
module cam_field_model #(
   parameter int unsigned NP = 2
) (
   input wire logic ref_clk_in,
   input wire logic [NP-1:0] pump_start_in,
   input wire logic [NP-1:0] fault_in,
   output logic [NP-1:0] contact_out,
   output logic [NP-1:0] current_out
);
   // Contactor pulls in one cycle after the start command
   always @(posedge ref_clk_in) begin
      contact_out <= pump_start_in;
   end
   // A faulty pump runs but draws no current
   assign current_out = contact_out & ~fault_in;
endmodule : cam_field_model

// ---- dv/cam_alarm_mon_bench.sv ----
`timescale 1ns/100ps
module cam_alarm_mon_bench;
   import cam_pkg::*;
   localparam int unsigned NP = 2;
   localparam int unsigned SC = 4; // Short second keeps the run brief
   localparam int unsigned MIN = SC*SEC_PER_MIN;
   localparam int unsigned PL = ALM_PUMP_BASE + NP; // Pump 0 lockout bit
   typedef struct packed {logic [1:0] c; logic [15:0] t; logic a;} cam_row_s;
   cam_row_s rows[4] = '{'{2'h1, 16'h0064, 1'b1}, '{2'h1, 16'h0065, 1'b0},
      '{2'h3, 16'h0048, 1'b1}, '{2'h3, 16'h0049, 1'b0}};
   logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, ce = 1'b1;
   logic lowf = 1'b1, hif = 1'b0, drn = 1'b0, summ, emer, irq;
   logic [NP-1:0] cmd = '0, flt = '0, con, cur, st;
   logic signed [TEMP_W-1:0] temp = 16'sh00c8;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wd = '0, rdat, rv;
   logic [PL+NP-1:0] alm;
   int n_fail = 0, comparisons = 0, cyc = 0;
   always #2 clk = ~clk;
   cam_alarm_mon #(.NUM_PUMPS(NP), .SEC_CYCLES(SC)) dut (
      .ref_clk_in(clk), .rst_b_in(rst_b), .ce_in(ce),
      .pump_contact_in(con), .pump_current_in(cur), .low_float_in(lowf),
      .high_float_in(hif), .drain_open_in(drn), .temp_in(temp),
      .pump_start_cmd_in(cmd), .reg_addr_in(addr), .reg_wdata_in(wd),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat),
      .pump_start_out(st), .alarm_out(alm), .summary_alarm_out(summ),
      .emergency_out(emer), .irq_out(irq));
   cam_field_model #(.NP(NP)) fm (.ref_clk_in(clk), .pump_start_in(st),
      .fault_in(flt), .contact_out(con), .current_out(cur));
   task automatic chk(input logic [31:0] g, e, input string m);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH t=%0t %s", $time, m);
      end
   endtask : chk
   // Settle past the edge so outputs are read after they land
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wt
   // One-cycle strobe; read data captured in the cycle after
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= w;
      rd <= ~w;
      addr <= a;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
      rv = rdat;
   endtask : bus
   task automatic end_of_test();
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_of_test
   // Hang guard well above the longest scenario
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_fail++;
         end_of_test();
      end
   end
   initial begin
      wt(20);
      chk(alm, 0, "reset alarms");
      rst_b <= 1'b1;
      bus(1'b0, REG_CTRL, 0);
      chk(rv, 1, "ctrl reset");
      bus(1'b0, 8'h20, 0);
      chk(rv, 0, "unmapped");
      bus(1'b1, REG_INT_MASK, 32'hff);
      foreach (rows[i]) begin
         bus(1'b1, REG_CTRL, 0);
         wt(3);
         chk(alm[ALM_LFT], 0, "ctrl release");
         temp <= rows[i].t;
         bus(1'b1, REG_CTRL, {30'h0, rows[i].c});
         wt(20);
         chk(alm[ALM_LFT], rows[i].a, "low temp");
         chk(emer, rows[i].a, "emergency");
      end
      $display("temp rows done");
      chk(irq, 1, "irq set");
      bus(1'b1, REG_INT_MASK, 0);
      wt(2);
      chk(irq, 0, "irq masked");
      bus(1'b1, REG_INT_MASK, 32'hff);
      bus(1'b1, REG_INT_STAT, 32'hff);
      wt(2);
      chk(irq, 0, "irq cleared");
      temp <= 16'sh0064;
      bus(1'b1, REG_CTRL, 1);
      wt(20);
      temp <= 16'sh0082;
      wt(20);
      chk(alm[ALM_LFT], 1, "held at 13.0");
      temp <= 16'sh0083;
      wt(20);
      chk(alm[ALM_LFT], 0, "released");
      $display("temp release done");
      ce <= 1'b0;
      bus(1'b1, REG_CTRL, 0);
      ce <= 1'b1;
      bus(1'b0, REG_CTRL, 0);
      chk(rv, 1, "enable low freezes bus");
      flt <= 2'b01;
      cmd <= 2'b11;
      for (int k = 0; k < 3; k++) begin
         wt(60);
         chk(alm[k == 2 ? PL : ALM_PUMP_BASE], 1, "pump");
         if (k == 1) flt[0] <= 1'b0;
         else cmd[0] <= 1'b0;
         wt(8);
         chk(alm[ALM_PUMP_BASE], 0, "pump release");
         flt[0] <= 1'b1;
         cmd[0] <= 1'b1;
      end
      wt(8);
      chk(st, 2'b10, "start inhibited");
      chk(alm[PL+1], 0, "healthy pump");
      bus(1'b0, REG_LOCK_STAT, 0);
      chk(rv, 32'h0003_0001, "lock stat");
      bus(1'b1, REG_LOCK_CLR, 1);
      wt(3);
      chk(alm[PL], 0, "lock cleared");
      chk(st, 2'b11, "start again");
      flt <= '0;
      $display("pump done");
      lowf <= 1'b0;
      hif <= 1'b1;
      wt(4*MIN);
      hif <= 1'b0;
      wt(8);
      hif <= 1'b1;
      wt(MIN);
      chk(alm[ALM_HIB], 0, "restart");
      chk(alm[ALM_LOWB], 1, "low basin");
      wt(4*MIN + 8);
      chk(alm[ALM_HIB], 1, "high basin");
      chk(summ, 1, "summary");
      lowf <= 1'b1;
      hif <= 1'b0;
      drn <= 1'b1;
      wt(20);
      chk(alm[ALM_LOWB], 0, "low release");
      chk(alm[ALM_HIB], 0, "high release");
      wt(45*MIN - 40);
      chk(alm[ALM_DRN], 0, "drain early");
      wt(40);
      chk(alm[ALM_DRN], 1, "drain fault");
      bus(1'b0, REG_ALARM, 0);
      chk(rv, 32'h08, "alarm word");
      bus(1'b0, REG_INT_STAT, 0);
      chk(rv, 32'h5f, "sticky events");
      lowf <= 1'b0;
      wt(20);
      chk(alm[ALM_DRN], 0, "drain release");
      chk(summ, 0, "summary clear");
      $display("basin done");
      end_of_test();
   end
endmodule : cam_alarm_mon_bench
